// file: verilog/cpwm_pkg.sv
// Behaviour
// R1: channels three and four form three pairs
// R2: mode drives all six pins, counters up/down
// R3: each phase has a gapped complement output
// R4: lead counter preloaded with margin, lag zero
// R5: period register is upper limit minus one
// R6: each transition register sets its pair edge
// R7: lead match turns down, lag underflow up
// R8: compare order lead, lag, lag, lead
// R9: transition above period gives 0% or 100%
// R10: one count overshoot and undershoot at turns
// R11: compare flag up only, overflow on underflow
// R12: buffers load at both direction turns
// R13: software avoids transitions below preload initially
// R14: software changes transitions through buffers only
// R15: up-to-down transfer keeps top range side
// R16: down-to-up transfer keeps bottom range side
// R17: out-of-range restore uses same direction
// R18: software writes buffers after turn events
// R19: quadrature phase relation steers quad counter
// R20: quad pins clock counter, clock selects ignored
// R21: quad clear, compare, capture, flags keep working
// R22: quadrature counting only on channel two
// R23: count every edge, A leading counts up
// R24: level select bits invert pair outputs
// R25: counter offset forms the dead time
`default_nettype none
package cpwm_pkg;
  // ==========================================================
  // register bus geometry and byte offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NPAIR = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LEAD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_LAG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TRANS0 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_BUF0 = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_QCTRL = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_QCNT = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_QGA = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_QGB = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_QIO = 8'h3c;
  localparam logic [ADDR_W-1:0] ADDR_QIE = 8'h40;
  // ==========================================================
  // fields
  localparam int ST_W = 5;
  localparam int ST_CMPA3 = 0;
  localparam int ST_OVF4 = 1;
  localparam int ST_QA = 2;
  localparam int ST_QB = 3;
  localparam int ST_QOVF = 4;
  localparam int QCTRL_W = 7;
  localparam int QCTRL_CLR_LSB = 5;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam int QIO_CAP_A = 0;
  localparam logic [DATA_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] GR_RST = 16'hffff;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_MAX = 16'hffff;
  typedef struct packed {
    logic ols23;
    logic ols1;
    logic quad_en;
    logic buf_en;
    logic run;
  } mode_ctrl_t;
  localparam int CTRL_W = 5;
  localparam mode_ctrl_t CTRL_RST = '{ols23: 1'b1, ols1: 1'b1, quad_en: 1'b0, buf_en: 1'b0, run: 1'b0};
  typedef struct packed {
    logic cap;
    logic b;
    logic a;
  } quad_pins_t;
  typedef struct packed {
    logic phase3_out_n;
    logic phase3_out;
    logic phase2_out_n;
    logic phase2_out;
    logic phase1_out_n;
    logic phase1_out;
  } pwm_pins_t;
endpackage
`default_nettype wire

// file: verilog/sync2.sv
`default_nettype none
// ==========================================================
// two-flop synchroniser; only the second stage is visible
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  if (WIDTH < 1) begin : g_chk
    $error("sync2 width must be at least one");
  end
  // meta stage feeds nothing but the output stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: verilog/phase_pair.sv
`default_nettype none
// ==========================================================
// one complementary output pair from the two counters
module phase_pair #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic en,
  input wire logic act_high,
  // counters and compare point
  input wire logic [W-1:0] lead,
  input wire logic [W-1:0] lag,
  input wire logic lag_neg,
  input wire logic [W-1:0] trans,
  // pins
  output logic out_p,
  output logic out_n
);
  logic act_p;
  logic act_n;
  if (W < 2) begin : g_chk
    $error("phase_pair width too small");
  end
  // phase on once the lower counter passed the point, complement on while the upper one is at or below it;
  // since lead stays above lag both can never be active together
  always_comb begin
    act_p = en && !lag_neg && (lag > trans); // [R25] [R6] [R9]
    act_n = en && (lead <= trans); // [R25] [R3] [R8]
  end
  // level select flips the active level at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else begin
      out_p <= act_high ? act_p : !act_p; // [R24]
      out_n <= act_high ? act_n : !act_n; // [R24]
    end
  end
  a_pair_no_overlap: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
    !((out_p == $past(act_high)) && (out_n == $past(act_high)) && $past(en)))
    else $error("pair outputs both active");
endmodule
`default_nettype wire

// file: verilog/cpwm_quad_timer.sv
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
// ==========================================================
// complementary pwm pair timer plus quadrature channel
module cpwm_quad_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [cpwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cpwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cpwm_pkg::DATA_W-1:0] reg_rdata,
  // quadrature encoder pins
  input wire cpwm_pkg::quad_pins_t quad_pins,
  // pwm pins and quad interrupt
  output cpwm_pkg::pwm_pins_t pwm_pins,
  output logic quad_irq
);
  import cpwm_pkg::*;
  // ==========================================================
  // state
  mode_ctrl_t ctrl_r;
  logic [DATA_W-1:0] lead_r;
  logic [DATA_W-1:0] lag_r;
  logic [DATA_W-1:0] period_r;
  logic [DATA_W-1:0] gr_r [NPAIR];
  logic [DATA_W-1:0] buf_r [NPAIR];
  logic [ST_W-1:0] status_r;
  logic [QCTRL_W-1:0] qctrl_r;
  logic [DATA_W-1:0] qcnt_r;
  logic [DATA_W-1:0] qga_r;
  logic [DATA_W-1:0] qgb_r;
  logic [QIO_CAP_A:0] qio_r;
  logic [ST_W-1:0] qie_r;
  logic dir_down_r;
  logic lag_neg_r;
  quad_pins_t qprev_r;
  quad_pins_t qs;
  logic [DATA_W-1:0] rdata_r;
  logic irq_r;
  logic [NPAIR-1:0] ph_p;
  logic [NPAIR-1:0] ph_n;
  logic cmp_a3;
  logic under4;
  logic turn;
  logic cnt_ev;
  logic q_up;
  logic qa_ev;
  logic qb_ev;
  logic qovf_ev;
  logic cap_ev;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [1:0] clr_sel;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] want);
    return a == want;
  endfunction

  // encoder pins come from outside: two flops before any use
  sync2 #(.WIDTH($bits(quad_pins_t))) u_qsync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .din(quad_pins),
    .dout(qs)
  );

  // ==========================================================
  // turn events of the counter pair
  always_comb begin
    cmp_a3 = ctrl_r.run && !dir_down_r && (lead_r == period_r); // [R7] [R5]
    under4 = ctrl_r.run && dir_down_r && (lag_r == CNT_RST); // [R7]
    turn = ctrl_r.run && ctrl_r.buf_en && (cmp_a3 || under4);
  end

  // mode and level select register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
    end else if (reg_wr && hit(reg_addr, ADDR_CTRL)) begin
      ctrl_r <= mode_ctrl_t'(reg_wdata[CTRL_W-1:0]);
    end
  end

  // both counters step each clock while running; a write always wins.
  // the increment at the lead match and the decrement at the lag underflow are the one-count over/undershoot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lead_r <= CNT_RST;
      lag_r <= CNT_RST;
    end else begin
      if (reg_wr && hit(reg_addr, ADDR_LEAD)) begin
        lead_r <= reg_wdata; // [R4]
      end else if (ctrl_r.run) begin
        lead_r <= dir_down_r ? lead_r - CNT_ONE : lead_r + CNT_ONE; // [R2] [R10]
      end
      if (reg_wr && hit(reg_addr, ADDR_LAG)) begin
        lag_r <= reg_wdata; // [R4]
      end else if (ctrl_r.run) begin
        lag_r <= dir_down_r ? lag_r - CNT_ONE : lag_r + CNT_ONE; // [R2] [R10]
      end
    end
  end

  // shared direction; stopping the pair restarts it counting up
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_down_r <= 1'b0;
    end else if (!ctrl_r.run) begin
      dir_down_r <= 1'b0;
    end else if (cmp_a3) begin
      dir_down_r <= 1'b1; // [R7]
    end else if (under4) begin
      dir_down_r <= 1'b0; // [R7]
    end
  end

  // marks the cycle the lag counter sits at all ones after underflow, so it reads as minus one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lag_neg_r <= 1'b0;
    end else begin
      lag_neg_r <= under4; // [R10]
    end
  end

  // period, transition and buffer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_r <= GR_RST;
    end else if (reg_wr && hit(reg_addr, ADDR_PERIOD)) begin
      period_r <= reg_wdata; // [R5]
    end
  end

  for (genvar i = 0; i < NPAIR; i++) begin : g_gr
    localparam logic [ADDR_W-1:0] A_TR = ADDR_TRANS0 + ADDR_W'(i) * ADDR_STEP;
    localparam logic [ADDR_W-1:0] A_BF = ADDR_BUF0 + ADDR_W'(i) * ADDR_STEP;
    // direct writes are honoured, though buffered updates are the safe path
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        gr_r[i] <= GR_RST;
      end else if (reg_wr && hit(reg_addr, A_TR)) begin
        gr_r[i] <= reg_wdata; // [R6] [R14]
      end else if (turn) begin
        gr_r[i] <= buf_r[i]; // [R12] [R15] [R16]
      end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        buf_r[i] <= GR_RST;
      end else if (reg_wr && hit(reg_addr, A_BF)) begin
        buf_r[i] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // output pairs: pair one on its own level bit, two and three share one
  for (genvar i = 0; i < NPAIR; i++) begin : g_pair
    phase_pair #(.W(DATA_W)) u_pair (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .en(ctrl_r.run), // [R1] [R2]
      .act_high(i == 0 ? ctrl_r.ols1 : ctrl_r.ols23), // [R24]
      .lead(lead_r),
      .lag(lag_r),
      .lag_neg(lag_neg_r),
      .trans(gr_r[i]),
      .out_p(ph_p[i]),
      .out_n(ph_n[i])
    );
  end
  always_comb begin
    pwm_pins = '{phase3_out_n: ph_n[2], phase3_out: ph_p[2], phase2_out_n: ph_n[1],
                 phase2_out: ph_p[1], phase1_out_n: ph_n[0], phase1_out: ph_p[0]}; // [R3]
  end

  // ==========================================================
  // quadrature decode; simultaneous edges on both inputs are dropped
  always_comb begin
    cnt_ev = ctrl_r.quad_en && ((qs.a ^ qprev_r.a) ^ (qs.b ^ qprev_r.b)); // [R20] [R23]
    q_up = !(qprev_r.a ^ qs.b); // [R19] [R23]
    clr_sel = qctrl_r[QCTRL_CLR_LSB +: 2];
    cap_ev = qio_r[QIO_CAP_A] && qs.cap && !qprev_r.cap;
    qa_ev = (cnt_ev && !qio_r[QIO_CAP_A] && (qcnt_r == qga_r)) || cap_ev; // [R21]
    qb_ev = cnt_ev && (qcnt_r == qgb_r); // [R21]
    qovf_ev = cnt_ev && (q_up ? (qcnt_r == CNT_MAX) : (qcnt_r == CNT_RST));
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qprev_r <= '0;
    end else begin
      qprev_r <= qs;
    end
  end

  // quad counter: clear source applies on the compare it names
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_r <= CNT_RST;
    end else if (reg_wr && hit(reg_addr, ADDR_QCNT)) begin
      qcnt_r <= reg_wdata;
    end else if (cnt_ev) begin
      if ((qa_ev && clr_sel == CLR_MATCH_A) || (qb_ev && clr_sel == CLR_MATCH_B)) begin
        qcnt_r <= CNT_RST; // [R21]
      end else begin
        qcnt_r <= q_up ? qcnt_r + CNT_ONE : qcnt_r - CNT_ONE; // [R19] [R22]
      end
    end
  end

  // quad config; clock source and edge fields are stored but have no effect
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qctrl_r <= '0;
      qio_r <= '0;
      qie_r <= '0;
      qgb_r <= GR_RST;
    end else begin
      if (reg_wr && hit(reg_addr, ADDR_QCTRL)) qctrl_r <= reg_wdata[QCTRL_W-1:0]; // [R20]
      if (reg_wr && hit(reg_addr, ADDR_QIO)) qio_r <= reg_wdata[QIO_CAP_A:0];
      if (reg_wr && hit(reg_addr, ADDR_QIE)) qie_r <= reg_wdata[ST_W-1:0];
      if (reg_wr && hit(reg_addr, ADDR_QGB)) qgb_r <= reg_wdata;
    end
  end

  // general a doubles as capture register; capture wins over a write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qga_r <= GR_RST;
    end else if (cap_ev) begin
      qga_r <= qcnt_r; // [R21]
    end else if (reg_wr && hit(reg_addr, ADDR_QGA)) begin
      qga_r <= reg_wdata;
    end
  end

  // ==========================================================
  // sticky flags: writing 0 clears, a same-cycle set wins
  always_comb begin
    st_set = '0;
    st_set[ST_CMPA3] = cmp_a3; // [R11]
    st_set[ST_OVF4] = under4; // [R11]
    st_set[ST_QA] = qa_ev;
    st_set[ST_QB] = qb_ev;
    st_set[ST_QOVF] = qovf_ev;
    st_clr = (reg_wr && hit(reg_addr, ADDR_STATUS)) ? ~reg_wdata[ST_W-1:0] : '0;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // enabled flags raise the quad interrupt level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & qie_r); // [R21]
    end
  end
  assign quad_irq = irq_r;

  // ==========================================================
  // read port: data one cycle after the strobe, zero otherwise
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      ADDR_CTRL: rd_mux = DATA_W'(ctrl_r);
      ADDR_LEAD: rd_mux = lead_r;
      ADDR_LAG: rd_mux = lag_r;
      ADDR_PERIOD: rd_mux = period_r;
      ADDR_TRANS0: rd_mux = gr_r[0];
      ADDR_TRANS0 + ADDR_STEP: rd_mux = gr_r[1];
      ADDR_BUF0 - ADDR_STEP: rd_mux = gr_r[2];
      ADDR_BUF0: rd_mux = buf_r[0];
      ADDR_BUF0 + ADDR_STEP: rd_mux = buf_r[1];
      ADDR_STATUS - ADDR_STEP: rd_mux = buf_r[2];
      ADDR_STATUS: rd_mux = DATA_W'(status_r);
      ADDR_QCTRL: rd_mux = DATA_W'(qctrl_r);
      ADDR_QCNT: rd_mux = qcnt_r;
      ADDR_QGA: rd_mux = qga_r;
      ADDR_QGB: rd_mux = qgb_r;
      ADDR_QIO: rd_mux = DATA_W'(qio_r);
      ADDR_QIE: rd_mux = DATA_W'(qie_r);
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_r;

  // ==========================================================
  // checks
  a_turn_down: assert property (@(posedge core_clk) disable iff (!rst_b) // [R7]
    cmp_a3 && !reg_wr |=> dir_down_r ##1 (lead_r == $past(period_r))) else $error("no turn at period match");
  a_over_shoot: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
    cmp_a3 && !reg_wr |=> lead_r == $past(period_r) + CNT_ONE) else $error("lead overshoot wrong");
  a_under_shoot: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
    under4 && !reg_wr |=> (lag_r == CNT_MAX) && !dir_down_r && lag_neg_r) else $error("lag undershoot wrong");
  a_cmpa_up_only: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
    $rose(status_r[ST_CMPA3]) |-> $past(ctrl_r.run && !dir_down_r)) else $error("compare flag outside up count");
  a_ovf_underflow: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
    $rose(status_r[ST_OVF4]) |-> $past(dir_down_r && lag_r == CNT_RST)) else $error("overflow flag without underflow");
  a_buf_load: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
    turn && !reg_wr |=> (gr_r[0] == $past(buf_r[0])) && (gr_r[2] == $past(buf_r[2]))) else $error("buffer not loaded");
  a_offset_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
    ctrl_r.run && !reg_wr ##1 ctrl_r.run |-> lead_r - lag_r == $past(lead_r - lag_r)) else $error("counter margin drifted");
  a_quad_up: assert property (@(posedge core_clk) disable iff (!rst_b) // [R23]
    cnt_ev && q_up && !qa_ev && !qb_ev && !reg_wr |=> qcnt_r == $past(qcnt_r) + CNT_ONE) else $error("quad up count");
  a_quad_down: assert property (@(posedge core_clk) disable iff (!rst_b) // [R23]
    cnt_ev && !q_up && !qa_ev && !qb_ev && !reg_wr |=> qcnt_r == $past(qcnt_r) - CNT_ONE) else $error("quad down count");
endmodule
`default_nettype wire

// file: verification/quad_encoder_model.sv
`default_nettype none
// ==========================================================
// quadrature encoder: one pin edge per requested step
module quad_encoder_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // step request from the bench
  input wire logic step_req,
  input wire logic step_up,
  // encoder and capture pins
  output cpwm_pkg::quad_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpwm_pkg::*;
  logic [1:0] phase_r;
  // phase walk; the bench spaces requests so the synchroniser sees each edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 2'h0;
    end else if (step_req) begin
      phase_r <= step_up ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end
  // phases 0..3 give (a,b) = 00,10,11,01: a leads b going up
  always_comb begin
    pins.a = phase_r[1] ^ phase_r[0];
    pins.b = phase_r[1];
    pins.cap = 1'b0; // capture pin not exercised
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
// ==========================================================
// register-level bench for the pwm pair timer and quad channel
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpwm_pkg::*;
  logic core_clk;
  logic rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  quad_pins_t quad_pins;
  pwm_pins_t pwm_pins;
  logic quad_irq;
  logic step_req;
  logic step_up;
  int errors;
  int num_checks;

  cpwm_quad_timer uut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .quad_pins(quad_pins),
    .pwm_pins(pwm_pins), .quad_irq(quad_irq)
  );
  quad_encoder_model enc (
    .core_clk(core_clk), .rst_b(rst_b), .step_req(step_req), .step_up(step_up), .pins(quad_pins)
  );

  // ==========================================================
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // bus tasks; strobes are one cycle, read data sampled in the following cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] msk);
    logic [DATA_W-1:0] d;
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    `CHK(d & msk, exp)
  endtask
  // encoder steps, spaced wider than the three-cycle minimum
  task automatic steps(input int n, input logic up);
    repeat (n) begin
      @(posedge core_clk);
      step_req <= 1'b1;
      step_up <= up;
      @(posedge core_clk);
      step_req <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
  // count active cycles per pin over two full up/down cycles, and pair overlaps
  task automatic measure(input logic [5:0] inv, input int e[6]);
    logic [7:0] c[6] = '{default: 8'h00}; // four-state, so an unknown pin shows as a mismatch
    logic [7:0] ov;
    logic [5:0] act;
    ov = 8'h00;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      act = pwm_pins ^ inv;
      for (int k = 0; k < 6; k++) c[k] += act[k];
      for (int p = 0; p < 3; p++) ov += act[2*p] & act[2*p+1];
    end
    for (int k = 0; k < 6; k++) `CHK(c[k], e[k])
    `CHK(ov, 0)
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // hang guard, far beyond the normal run length
  initial begin
    #500us;
    errors++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    step_req = 1'b0;
    step_up = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    `CHK(pwm_pins, 6'h00)
    rd_chk(ADDR_CTRL, 16'h0018, 16'hffff);
    rd_chk(ADDR_PERIOD, 16'hffff, 16'hffff);
    rd_chk(ADDR_LAG, 16'h0000, 16'hffff);
    rd_chk(8'h44, 16'h0000, 16'hffff);
    $display("test reset done");
    // quad counting; clock select bits set but must not matter
    wr(ADDR_CTRL, 16'h001c);
    wr(ADDR_QCTRL, 16'h001f);
    steps(4, 1'b1);
    rd_chk(ADDR_QCNT, 16'h0004, 16'hffff);
    steps(6, 1'b0);
    rd_chk(ADDR_QCNT, 16'hfffe, 16'hffff);
    // clear on match A at 2, with its interrupt enabled
    wr(ADDR_QCNT, 16'h0000);
    wr(ADDR_QGA, 16'h0002);
    wr(ADDR_QCTRL, 16'h003f);
    wr(ADDR_STATUS, 16'h0000); // flags left by the wrap above must not hide the match
    wr(ADDR_QIE, 16'h0004);
    #1 `CHK(quad_irq, 1'b0)
    steps(3, 1'b1);
    rd_chk(ADDR_QCNT, 16'h0000, 16'hffff);
    rd_chk(ADDR_STATUS, 16'h0004, 16'h0004);
    `CHK(quad_irq, 1'b1)
    $display("test quad done");
    // pwm: margin 2, period 5, all transitions 3; buffers match so enabling them changes nothing
    rd_chk(ADDR_STATUS, 16'h0000, 16'h0003);
    wr(ADDR_LEAD, 16'h0002);
    wr(ADDR_LAG, 16'h0000);
    wr(ADDR_PERIOD, 16'h0005);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TRANS0 + ADDR_STEP * 8'(i), 16'h0003);
      wr(ADDR_BUF0 + ADDR_STEP * 8'(i), 16'h0003);
    end
    wr(ADDR_CTRL, 16'h001d);
    repeat (12) @(posedge core_clk);
    // ten-cycle period: lag 0..4 up, 3..0 down, one undershoot
    measure(6'h00, '{2, 10, 2, 10, 2, 10});
    rd_chk(ADDR_STATUS, 16'h0003, 16'h0003);
    $display("test pwm done");
    // buffered move of pair 1 beyond the period, with pair 1 levels inverted
    wr(ADDR_BUF0, 16'h0010);
    wr(ADDR_CTRL, 16'h0017);
    repeat (12) @(posedge core_clk);
    measure(6'h03, '{0, 20, 2, 10, 2, 10});
    $display("test duty and level done");
    final_report();
  end
endmodule
`default_nettype wire
